// >>> rtl/dtm_pkg.sv
`include "dtm_regs.svh"
package dtm_pkg;
	// decoded operating mode of one timer
	typedef enum logic [2:0] {DTM_SOLO, DTM_CASCADE, DTM_CARRIER, DTM_PWM, DTM_PULSE,
		DTM_BAD} dtm_mode_t;
	// whole state of the block
	typedef struct packed {
		logic [7:0] ctrl_a;
		logic [7:0] ctrl_b;
		logic [7:0] cmp_a;
		logic [7:0] cmp_bl;
		logic [7:0] cmp_bh;
		logic [7:0] cnt_a;
		logic [7:0] cnt_b;
		logic [`DTM_IRQ_W-1:0] irq_st;
		logic [`DTM_IRQ_W-1:0] irq_mask;
		logic irq;
		logic [31:0] rdata;
		logic wr_pend;
		logic [15:0] wr_idx;
		logic [2:0] sub_sync;
		logic [2:0] ext_sync;
		logic sub_lvl;
		logic ext_lvl;
		logic ext_prev;
		logic [`DTM_PRESC_W-1:0] presc;
		logic [`DTM_EXT_DIV_W-1:0] ext_div;
		logic a_prev;
		logic b_prev;
		logic out_a;
		logic out_b;
		logic pin_a;
		logic pin_b;
	} dtm_state_t;
endpackage

// >>> rtl/dtm_regs.svh
`ifndef DTM_REGS_SVH
`define DTM_REGS_SVH
// register word indices, byte address is four times the index
`define DTM_IDX_CTRL_A 16'hFF4D
`define DTM_IDX_CTRL_B 16'hFF4E
`define DTM_IDX_CMP_A 16'hFF50
`define DTM_IDX_CMP_BL 16'hFF51
`define DTM_IDX_CMP_BH 16'hFF52
`define DTM_IDX_CNT_A 16'hFF53
`define DTM_IDX_CNT_B 16'hFF54
`define DTM_IDX_IRQ_ST 16'hFF55
`define DTM_IDX_IRQ_MASK 16'hFF56
`define DTM_IDX_BIT_SET 16'hFF57
`define DTM_IDX_BIT_CLR 16'hFF58
// control register fields
`define DTM_EN 7
`define DTM_A_EDGE 6
`define DTM_CLK_HI 5
`define DTM_CLK_LO 3
`define DTM_MODE_HI 2
`define DTM_MODE_LO 1
`define DTM_OE 0
`define DTM_CTRL_RST 8'h00
`define DTM_CTRL_B_MASK 8'hBF
// mode patterns {a1,a0,b1,b0}
`define DTM_M_CASCADE 4'h5
`define DTM_M_CARRIER 4'h3
// timer a clock codes
`define DTM_CLK_MAIN 3'h0
`define DTM_A_DIV8 3'h1
`define DTM_A_DIV128 3'h2
`define DTM_A_SUB 3'h3
`define DTM_A_BMATCH 3'h4
`define DTM_A_BOUT 3'h5
// timer b clock codes
`define DTM_B_DIV4 3'h1
`define DTM_B_EXT 3'h2
`define DTM_B_EXT2 3'h3
`define DTM_B_EXT4 3'h4
`define DTM_B_EXT8 3'h5
// prescaler taps and widths
`define DTM_PRESC_W 7
`define DTM_TAP_DIV4 1
`define DTM_TAP_DIV8 2
`define DTM_TAP_DIV128 6
`define DTM_EXT_DIV_W 3
`define DTM_CNT_MAX 8'hFF
// interrupt status bits
`define DTM_IRQ_MATCH_A 0
`define DTM_IRQ_OVF_A 1
`define DTM_IRQ_MATCH_B 2
`define DTM_IRQ_OVF_B 3
`define DTM_IRQ_W 4
`endif

// >>> rtl/dtm_timer.sv
// Chosen here: the AHB-Lite register port.
`timescale 1ns/100ps
`include "dtm_regs.svh"
// Operation
// RULE1: shaped b modes clear on either compare, overflow
// RULE2: pwm clears only on overflow, not match
// RULE3: a enable low clears and stops counter
// RULE4: both edges counted only in pwm mode
// RULE5: timer a clock select decode
// RULE6: timer a mode decode from four bits
// RULE7: timer b mode decode from four bits
// RULE8: cascade: b enable clears or starts both
// RULE9: cascade ignores timer a enable bit
// RULE10: cascade disables timer a output pin
// RULE11: cascade forces b output as a clock
// RULE12: software stops counter before changing mode
// RULE13: timer b clock select decode
// RULE14: output enable gates timer output pin
// RULE15: control registers reset to zero
// RULE16: single bit set and clear writes
// RULE17: stand-alone clears on match and overflow
// RULE18: external inputs synchronised before counting
module dtm_timer (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic sub_clk,
	input wire logic ext_event,
	output logic timer_a_out,
	output logic timer_b_out,
	output logic irq
);
	// mode decode for timer a
	function automatic dtm_pkg::dtm_mode_t dec_a(input logic [3:0] m);
		if (m == `DTM_M_CASCADE)
			return dtm_pkg::DTM_CASCADE;
		else if (m == `DTM_M_CARRIER)
			return dtm_pkg::DTM_CARRIER;
		else if (m[3:2] == 2'h0 && !m[0])
			return dtm_pkg::DTM_SOLO;
		else if (m[3:2] == 2'h2 && !m[0])
			return dtm_pkg::DTM_PWM;
		else
			return dtm_pkg::DTM_BAD;
	endfunction

	// mode decode for timer b
	function automatic dtm_pkg::dtm_mode_t dec_b(input logic [3:0] m);
		if (m == `DTM_M_CASCADE)
			return dtm_pkg::DTM_CASCADE;
		else if (m == `DTM_M_CARRIER)
			return dtm_pkg::DTM_CARRIER;
		else if (m[2:0] == 3'h0)
			return dtm_pkg::DTM_SOLO;
		else if (m[2:0] == 3'h2)
			return dtm_pkg::DTM_PULSE;
		else
			return dtm_pkg::DTM_BAD;
	endfunction

	// level of the selected timer a clock source
	function automatic logic mux_a(input logic [2:0] sel, input dtm_pkg::dtm_state_t st);
		case (sel)
			`DTM_A_DIV8: return st.presc[`DTM_TAP_DIV8];
			`DTM_A_DIV128: return st.presc[`DTM_TAP_DIV128];
			`DTM_A_SUB: return st.sub_lvl;
			`DTM_A_BOUT: return st.out_b;
			default: return 1'b0;
		endcase
	endfunction

	// level of the selected timer b clock source
	function automatic logic mux_b(input logic [2:0] sel, input dtm_pkg::dtm_state_t st);
		case (sel)
			`DTM_B_DIV4: return st.presc[`DTM_TAP_DIV4];
			`DTM_B_EXT: return st.ext_lvl;
			`DTM_B_EXT2: return st.ext_div[0];
			`DTM_B_EXT4: return st.ext_div[1];
			`DTM_B_EXT8: return st.ext_div[2];
			default: return 1'b0;
		endcase
	endfunction

	// register read mux, unmapped words read zero
	function automatic logic [31:0] rd_mux(input logic [15:0] i, input dtm_pkg::dtm_state_t st);
		case (i)
			`DTM_IDX_CTRL_A: return {24'h000000, st.ctrl_a};
			`DTM_IDX_CTRL_B: return {24'h000000, st.ctrl_b};
			`DTM_IDX_CMP_A: return {24'h000000, st.cmp_a};
			`DTM_IDX_CMP_BL: return {24'h000000, st.cmp_bl};
			`DTM_IDX_CMP_BH: return {24'h000000, st.cmp_bh};
			`DTM_IDX_CNT_A: return {24'h000000, st.cnt_a};
			`DTM_IDX_CNT_B: return {24'h000000, st.cnt_b};
			`DTM_IDX_IRQ_ST: return {28'h0000000, st.irq_st};
			`DTM_IDX_IRQ_MASK: return {28'h0000000, st.irq_mask};
			default: return 32'h00000000;
		endcase
	endfunction

	dtm_pkg::dtm_state_t s; // registered state
	dtm_pkg::dtm_state_t n; // next state
	dtm_pkg::dtm_mode_t mode_a; // decoded mode of a
	dtm_pkg::dtm_mode_t mode_b; // decoded mode of b
	logic [3:0] mode_bits; // {a1,a0,b1,b0}
	logic [2:0] sel_a; // a clock code
	logic [2:0] sel_b; // b clock code
	logic cascade; // 16-bit chain active
	logic pwm; // a in pulse-width mode
	logic b_shaped; // b in carrier or pulse mode
	logic a_en; // effective a enable
	logic b_en; // b enable
	logic a_lvl; // a source level
	logic b_lvl; // b source level
	logic a_edge; // a valid edge seen
	logic a_tick; // a count step
	logic b_tick; // b count step
	logic [7:0] b_cmp; // compare for b phase
	logic a_match; // a equals compare
	logic a_ovf; // a at top
	logic b_match; // b equals compare
	logic b_ovf; // b at top
	logic c_match; // chained match
	logic c_ovf; // chained overflow
	logic b_match_sig; // b match pulse
	logic ext_rise; // filtered external rising edge
	logic acc; // address phase taken
	logic addr_ok; // address inside decoded window
	logic [`DTM_IRQ_W-1:0] ev; // events this cycle
	logic [`DTM_IRQ_W-1:0] clr; // write-one clears

	// mode decode
	assign mode_bits = {s.ctrl_a[`DTM_MODE_HI:`DTM_MODE_LO], s.ctrl_b[`DTM_MODE_HI:`DTM_MODE_LO]};
	assign mode_a = dec_a(mode_bits); // RULE6
	assign mode_b = dec_b(mode_bits); // RULE7
	assign cascade = (mode_a == dtm_pkg::DTM_CASCADE);
	assign pwm = (mode_a == dtm_pkg::DTM_PWM);
	assign b_shaped = (mode_b == dtm_pkg::DTM_PULSE) || (mode_b == dtm_pkg::DTM_CARRIER);
	assign sel_a = s.ctrl_a[`DTM_CLK_HI:`DTM_CLK_LO];
	assign sel_b = s.ctrl_b[`DTM_CLK_HI:`DTM_CLK_LO];

	// enables, in cascade only b's enable counts
	assign a_en = cascade ? s.ctrl_b[`DTM_EN] : s.ctrl_a[`DTM_EN]; // RULE9
	assign b_en = s.ctrl_b[`DTM_EN];

	// timer b clock; prohibited codes never tick
	assign b_lvl = mux_b(sel_b, s); // RULE13
	assign b_tick = b_en && (mode_b != dtm_pkg::DTM_BAD) && ((sel_b == `DTM_CLK_MAIN) ||
		(sel_b <= `DTM_B_EXT8 && b_lvl && !s.b_prev));

	// timer b compare and chained compare
	assign b_cmp = (b_shaped && s.out_b) ? s.cmp_bh : s.cmp_bl;
	assign b_match = (s.cnt_b == b_cmp);
	assign b_ovf = (s.cnt_b == `DTM_CNT_MAX);
	assign c_match = cascade && ({s.cnt_a, s.cnt_b} == {s.cmp_a, s.cmp_bl});
	assign c_ovf = cascade && (s.cnt_a == `DTM_CNT_MAX) && b_ovf;
	assign b_match_sig = b_tick && (cascade ? c_match : b_match);

	// timer a clock; falling edges only count in pwm
	assign a_lvl = mux_a(sel_a, s); // RULE5
	assign a_edge = (a_lvl && !s.a_prev) ||
		(pwm && s.ctrl_a[`DTM_A_EDGE] && !a_lvl && s.a_prev); // RULE4
	assign a_tick = a_en && !cascade && (mode_a != dtm_pkg::DTM_BAD) &&
		((sel_a == `DTM_CLK_MAIN) || (sel_a == `DTM_A_BMATCH && b_match_sig) ||
		(sel_a <= `DTM_A_BOUT && sel_a != `DTM_A_BMATCH && a_edge)); // RULE5
	assign a_match = (s.cnt_a == s.cmp_a);
	assign a_ovf = (s.cnt_a == `DTM_CNT_MAX);

	// bus address phase
	assign ext_rise = s.ext_lvl && !s.ext_prev;
	assign addr_ok = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0);
	assign acc = hsel && htrans[1] && hready && (hsize == 3'h2);

	// next-state logic
	always_comb
	begin
		n = s;
		ev = '0;
		clr = '0;
		// three-stage synchronisers, a change counts once stages two and three agree
		n.sub_sync = {s.sub_sync[1:0], sub_clk}; // RULE18
		n.ext_sync = {s.ext_sync[1:0], ext_event}; // RULE18
		if (s.sub_sync[2] == s.sub_sync[1])
			n.sub_lvl = s.sub_sync[2];
		if (s.ext_sync[2] == s.ext_sync[1])
			n.ext_lvl = s.ext_sync[2];
		n.ext_prev = s.ext_lvl;
		// free-running prescaler and external divider
		n.presc = s.presc + `DTM_PRESC_W'(1);
		if (ext_rise)
			n.ext_div = s.ext_div + `DTM_EXT_DIV_W'(1);
		n.a_prev = a_lvl;
		n.b_prev = b_lvl;
		// timer b, which also carries a in cascade
		if (!b_en)
		begin
			n.cnt_b = 8'h00; // RULE1
			n.out_b = 1'b0;
			if (cascade)
				n.cnt_a = 8'h00; // RULE8
		end
		else if (b_tick)
		begin
			if (cascade)
			begin
				if (c_match || c_ovf)
				begin
					n.cnt_a = 8'h00;
					n.cnt_b = 8'h00;
					ev[`DTM_IRQ_MATCH_B] = c_match;
					ev[`DTM_IRQ_OVF_B] = c_ovf;
					n.out_b = c_match ? !s.out_b : s.out_b;
				end
				else
				begin
					n.cnt_b = s.cnt_b + 8'h01;
					// carry out of b clocks a, whatever a's code says
					if (b_ovf)
						n.cnt_a = s.cnt_a + 8'h01; // RULE11
				end
			end
			else if (b_match)
			begin
				// match ends the current phase
				n.cnt_b = 8'h00; // RULE1 RULE17
				n.out_b = !s.out_b;
				ev[`DTM_IRQ_MATCH_B] = 1'b1;
			end
			else if (b_ovf)
			begin
				n.cnt_b = 8'h00; // RULE1 RULE17
				ev[`DTM_IRQ_OVF_B] = 1'b1;
				// a lost phase restarts low
				if (b_shaped)
					n.out_b = 1'b0;
			end
			else
				n.cnt_b = s.cnt_b + 8'h01;
		end
		// timer a on its own clock
		if (!cascade)
		begin
			if (!a_en)
			begin
				n.cnt_a = 8'h00; // RULE3
				n.out_a = 1'b0;
			end
			else if (a_tick)
			begin
				if (pwm)
				begin
					// period is free-running, match only drops the output
					if (a_ovf)
					begin
						n.cnt_a = 8'h00; // RULE2
						n.out_a = 1'b1;
						ev[`DTM_IRQ_OVF_A] = 1'b1;
					end
					else
					begin
						n.cnt_a = s.cnt_a + 8'h01; // RULE2
						if (a_match)
						begin
							n.out_a = 1'b0;
							ev[`DTM_IRQ_MATCH_A] = 1'b1;
						end
					end
				end
				else if (a_match)
				begin
					n.cnt_a = 8'h00; // RULE17
					n.out_a = !s.out_a;
					ev[`DTM_IRQ_MATCH_A] = 1'b1;
				end
				else if (a_ovf)
				begin
					n.cnt_a = 8'h00; // RULE17
					ev[`DTM_IRQ_OVF_A] = 1'b1;
				end
				else
					n.cnt_a = s.cnt_a + 8'h01;
			end
		end
		// output pins, a is always off in cascade
		n.pin_a = s.out_a && s.ctrl_a[`DTM_OE] && !cascade; // RULE10 RULE14
		n.pin_b = s.out_b && s.ctrl_b[`DTM_OE]; // RULE14
		// sticky events; a new event beats a same-cycle clear
		if (s.wr_pend && s.wr_idx == `DTM_IDX_IRQ_ST)
			clr = hwdata[`DTM_IRQ_W-1:0];
		n.irq_st = (s.irq_st & ~clr) | ev;
		// write data phase; the wait state lets a following read see it
		if (s.wr_pend)
		begin
			n.wr_pend = 1'b0;
			case (s.wr_idx)
				`DTM_IDX_CTRL_A: n.ctrl_a = hwdata[7:0];
				`DTM_IDX_CTRL_B: n.ctrl_b = hwdata[7:0] & `DTM_CTRL_B_MASK;
				`DTM_IDX_CMP_A: n.cmp_a = hwdata[7:0];
				`DTM_IDX_CMP_BL: n.cmp_bl = hwdata[7:0];
				`DTM_IDX_CMP_BH: n.cmp_bh = hwdata[7:0];
				`DTM_IDX_IRQ_MASK: n.irq_mask = hwdata[`DTM_IRQ_W-1:0];
				// single control bits change without touching the rest
				`DTM_IDX_BIT_SET:
				begin
					n.ctrl_a = s.ctrl_a | hwdata[7:0]; // RULE16
					n.ctrl_b = (s.ctrl_b | hwdata[15:8]) & `DTM_CTRL_B_MASK; // RULE16
				end
				`DTM_IDX_BIT_CLR:
				begin
					n.ctrl_a = s.ctrl_a & ~hwdata[7:0]; // RULE16
					n.ctrl_b = s.ctrl_b & ~hwdata[15:8]; // RULE16
				end
				default: ;
			endcase
		end
		n.irq = |(n.irq_st & n.irq_mask);
		// address phase
		if (acc)
		begin
			if (hwrite)
			begin
				n.wr_pend = 1'b1;
				n.wr_idx = addr_ok ? haddr[17:2] : 16'h0000;
			end
			else
				n.rdata = addr_ok ? rd_mux(haddr[17:2], s) : 32'h00000000;
		end
	end

	// state register, frozen while ce is low
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			s <= '0; // RULE15
		else if (ce)
			s <= n;
	end

	// ports
	assign hreadyout = !s.wr_pend;
	assign hresp = 1'b0;
	assign hrdata = s.rdata;
	assign timer_a_out = s.pin_a;
	assign timer_b_out = s.pin_b;
	assign irq = s.irq;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence cas_stop_s;
		ce && cascade && !s.ctrl_b[`DTM_EN];
	endsequence

	sequence cas_carry_s;
		ce && cascade && b_tick && b_ovf && !c_ovf && !c_match;
	endsequence

	a_disable_clear_a: assert property (ce && !cascade && !s.ctrl_a[`DTM_EN] |=> // RULE3
		s.cnt_a == 8'h00 && !s.out_a) else $error("a not cleared when disabled");
	pwm_free_run_a: assert property (ce && a_tick && pwm && a_match && !a_ovf |=> // RULE2
		s.cnt_a == $past(s.cnt_a) + 8'h01) else $error("pwm match cleared counter");
	shaped_clear_a: assert property (ce && b_tick && b_shaped && (b_match || b_ovf) |=> // RULE1
		s.cnt_b == 8'h00) else $error("shaped b not cleared");
	solo_clear_a: assert property (ce && a_tick && mode_a == dtm_pkg::DTM_SOLO && a_match // RULE17
		|=> s.cnt_a == 8'h00 && s.out_a != $past(s.out_a)) else $error("solo a no clear");
	edge_solo_a: assert property (mode_a != dtm_pkg::DTM_PWM && sel_a != `DTM_CLK_MAIN && // RULE4
		sel_a != `DTM_A_BMATCH && !(a_lvl && !s.a_prev) |-> !a_tick)
		else $error("non-rising edge counted");
	clk_div8_a: assert property (a_tick && sel_a == `DTM_A_DIV8 && !pwm |-> // RULE5
		s.presc[`DTM_TAP_DIV8] && !s.a_prev) else $error("a div8 tick off phase");
	clk_div4_a: assert property (b_tick && sel_b == `DTM_B_DIV4 |-> // RULE13
		s.presc[`DTM_TAP_DIV4] && !s.b_prev) else $error("b div4 tick off phase");
	ext_sync_a: assert property (b_tick && sel_b == `DTM_B_EXT |-> // RULE18
		s.ext_lvl && !s.ext_prev) else $error("b counted unsynchronised edge");
	mode_decode_a: assert property (mode_bits == `DTM_M_CASCADE |-> // RULE6
		mode_b == dtm_pkg::DTM_CASCADE) else $error("cascade decode mismatch");
	mode_pulse_a: assert property (mode_bits[2:0] == 3'h2 |-> // RULE7
		mode_b == dtm_pkg::DTM_PULSE) else $error("pulse decode mismatch");
	cascade_stop_a: assert property (cas_stop_s |=> // RULE8
		s.cnt_a == 8'h00 && s.cnt_b == 8'h00) else $error("cascade stop missed");
	cascade_carry_a: assert property (cas_carry_s |=> // RULE9 RULE11
		s.cnt_a == $past(s.cnt_a) + 8'h01) else $error("cascade carry lost");
	cascade_pin_a: assert property (ce && cascade |=> !timer_a_out) // RULE10
		else $error("a pin on in cascade");
	oe_gate_a: assert property (ce && !s.ctrl_b[`DTM_OE] |=> !timer_b_out) // RULE14
		else $error("b pin on while disabled");
	bit_set_a: assert property (ce && s.wr_pend && s.wr_idx == `DTM_IDX_BIT_SET |=> // RULE16
		(s.ctrl_a & $past(hwdata[7:0])) == $past(hwdata[7:0])) else $error("bit set lost");
	reset_ctrl_a: assert property (disable iff (1'b0) !resetn |-> // RULE15
		s.ctrl_a == `DTM_CTRL_RST && s.ctrl_b == `DTM_CTRL_RST) else $error("ctrl not reset");
	sticky_set_a: assert property (ce && ev[`DTM_IRQ_MATCH_A] |=> s.irq_st[`DTM_IRQ_MATCH_A])
		else $error("event lost against clear");
endmodule

// >>> test/dtm_pins.sv
`timescale 1ns/100ps
// far-side pins: subsystem clock and event input, both resting low between bursts
module dtm_pins (
	input wire logic core_clk,
	output logic sub_clk,
	output logic ext_event
);
	// half period in core cycles, long enough for the two-sample input filter
	localparam int half = 4;
	// both pins idle low outside bursts, never left floating
	initial
	begin
		sub_clk = 1'b0;
		ext_event = 1'b0;
	end
	// n whole pulses on one pin; edges land just after core edges, unrelated to the bus
	task automatic pulse(input logic on_sub, input int n);
		repeat (n)
		begin
			repeat (half) @(posedge core_clk);
			if (on_sub)
				sub_clk <= 1'b1;
			else
				ext_event <= 1'b1;
			repeat (half) @(posedge core_clk);
			sub_clk <= 1'b0;
			ext_event <= 1'b0;
		end
	endtask
endmodule

// >>> test/testbench.sv
`timescale 1ns/100ps
`include "dtm_regs.svh"
module testbench;
	// register word indices used by the scenarios
	localparam logic [15:0] ia = `DTM_IDX_CTRL_A;
	localparam logic [15:0] ib = `DTM_IDX_CTRL_B;
	localparam logic [15:0] icmpa = `DTM_IDX_CMP_A;
	localparam logic [15:0] icmpl = `DTM_IDX_CMP_BL;
	localparam logic [15:0] icmph = `DTM_IDX_CMP_BH;
	localparam logic [15:0] icnta = `DTM_IDX_CNT_A;
	localparam logic [15:0] icntb = `DTM_IDX_CNT_B;
	localparam logic [15:0] ist = `DTM_IDX_IRQ_ST;
	localparam logic [15:0] imask = `DTM_IDX_IRQ_MASK;
	localparam logic [15:0] iset = `DTM_IDX_BIT_SET;
	localparam logic [15:0] iclr = `DTM_IDX_BIT_CLR;
	// bus and pin nets
	logic core_clk;
	logic resetn;
	logic ce;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [31:0] hwdata;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic sub_clk;
	logic ext_event;
	logic timer_a_out;
	logic timer_b_out;
	logic irq;
	// last read word and pin watch flags
	logic [31:0] rd_s;
	logic hi;
	logic lo;
	int nb; // samples with the timer b pin high
	int bad_count = 0;
	int n_checks = 0;

	// word size is tied to a word and hready is tied back to hreadyout, the master only moves whole words
	dtm_timer dtm_timer_inst (.core_clk(core_clk), .resetn(resetn), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.sub_clk(sub_clk), .ext_event(ext_event), .timer_a_out(timer_a_out),
		.timer_b_out(timer_b_out), .irq(irq));
	dtm_pins dtm_pins_inst (.core_clk(core_clk), .sub_clk(sub_clk), .ext_event(ext_event));

	// 20 MHz core clock
	always #25 core_clk = ~core_clk;

	// verdict and end of run, also reached from any exhausted wait
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// one comparison, four-state exact
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// wait for hready high at a rising edge; level taken mid-cycle, settled by then
	task automatic wait_rdy();
		logic r;
		for (int i = 0; i < 20; i++)
		begin
			@(negedge core_clk);
			r = hreadyout;
			rd_s = hrdata;
			@(posedge core_clk);
			if (r === 1'b1)
				return;
		end
		bad_count++;
		$display("wrong value at %0t: bus never ready", $time);
		report_and_stop();
	endtask

	// single word transfer: address phase held until taken, then data phase
	task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {14'h0000, idx, 2'h0};
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
	endtask

	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		bus(1'b1, idx, d);
	endtask

	// read and compare exactly
	task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0);
		chk(rd_s, exp);
	endtask

	// read and accept a small window, for counts whose phase is not pinned down
	task automatic rng(input logic [15:0] idx, input logic [31:0] l, input logic [31:0] h);
		bus(1'b0, idx, 32'h0);
		chk({31'h0, rd_s >= l && rd_s <= h}, 32'h1);
	endtask

	// let registered outputs such as irq catch up
	task automatic settle();
		repeat (3) @(posedge core_clk);
		#1;
	endtask

	// record which levels the timer a pin took over n cycles
	task automatic watch(input int n);
		hi = 1'b0;
		lo = 1'b0;
		nb = 0;
		repeat (n)
		begin
			@(posedge core_clk);
			#1;
			hi = hi | (timer_a_out === 1'b1);
			lo = lo | (timer_a_out === 1'b0);
			nb += (timer_b_out === 1'b1);
		end
	endtask

	// reset values, and a stray index that must read zero and swallow writes
	task automatic t_reset();
		chk({29'h0, timer_a_out, timer_b_out, irq}, 32'h0);
		rdc(ia, 32'h0);
		rdc(ib, 32'h0);
		wr(16'hFF70, 32'hFF);
		rdc(16'hFF70, 32'h0);
	endtask

	// byte writes, then single bits set and cleared through the alias words
	task automatic t_bits();
		wr(ib, 32'h7F);
		rdc(ib, 32'h3F);
		wr(iset, 32'h0001);
		rdc(ia, 32'h01);
		wr(iclr, 32'h0801);
		rdc(ia, 32'h00);
		rdc(ib, 32'h37);
		rdc(iset, 32'h0);
		wr(ib, 32'h0);
	endtask

	// stand-alone compare clear, enable clear, and the masked interrupt path
	task automatic t_solo();
		wr(imask, 32'h0);
		wr(icmpa, 32'h05);
		wr(ia, 32'h80);
		repeat (4) rng(icnta, 32'h0, 32'h5);
		rdc(ist, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wr(imask, 32'h1);
		settle();
		chk({31'h0, irq}, 32'h1);
		wr(ia, 32'h0);
		rdc(icnta, 32'h0);
		wr(ist, 32'h1);
		settle();
		chk({31'h0, irq}, 32'h0);
		rdc(ist, 32'h0);
		wr(imask, 32'h0);
	endtask

	// pwm free-runs through the compare value up to overflow; pin gated by its enable
	task automatic t_pwm();
		wr(icmpa, 32'h10);
		wr(ia, 32'h45);
		wr(ia, 32'hC5);
		watch(600);
		chk({30'h0, hi, lo}, 32'h3);
		bus(1'b0, ist, 32'h0);
		chk({31'h0, rd_s[`DTM_IRQ_OVF_A]}, 32'h1);
		wr(ia, 32'h44);
		wr(ist, 32'hF);
		wr(ia, 32'hC4);
		watch(600);
		chk({31'h0, hi}, 32'h0);
		wr(ia, 32'h44);
		wr(ia, 32'h4C);
		wr(ia, 32'hCC);
		repeat (80) @(posedge core_clk);
		rng(icnta, 32'd19, 32'd22);
		wr(ia, 32'h0);
	endtask

	// cascade: a enable ignored, b enable runs and clears both, a pin stays off
	task automatic t_cascade();
		wr(icmpa, 32'hFF);
		wr(icmpl, 32'hFF);
		wr(ia, 32'h03);
		wr(ib, 32'h02);
		wr(ia, 32'h83);
		watch(20);
		rdc(icnta, 32'h0);
		wr(ib, 32'h82);
		watch(700);
		chk({31'h0, hi}, 32'h0);
		rng(icnta, 32'h2, 32'h3);
		wr(ib, 32'h02);
		rdc(icnta, 32'h0);
		rdc(icntb, 32'h0);
		wr(ia, 32'h0);
		wr(ib, 32'h0);
	endtask

	// stop, pick the clock, start, feed pin pulses or wait, then judge the count
	task automatic run_clk(input logic [15:0] ci, input logic [15:0] ni, input logic [2:0] code,
		input int src, input int n, input int w, input logic [31:0] l, input logic [31:0] h);
		wr(ci, {26'h0, code, 3'h0});
		wr(ci, {24'h0, 2'h2, code, 3'h0});
		if (src != 0)
			dtm_pins_inst.pulse(src == 2, n);
		repeat (w) @(posedge core_clk);
		rng(ni, l, h);
		wr(ci, 32'h0);
	endtask

	// every clock code of timer b and codes 0 to 3 of timer a, plus one prohibited code that must not count
	task automatic t_clocks();
		run_clk(ib, icntb, 3'h0, 0, 0, 40, 32'd38, 32'd46);
		run_clk(ib, icntb, 3'h1, 0, 0, 40, 32'd9, 32'd12);
		run_clk(ib, icntb, 3'h2, 1, 5, 6, 32'd5, 32'd5);
		run_clk(ib, icntb, 3'h3, 1, 6, 6, 32'd2, 32'd3);
		run_clk(ib, icntb, 3'h4, 1, 8, 6, 32'd1, 32'd2);
		run_clk(ib, icntb, 3'h5, 1, 16, 6, 32'd1, 32'd2);
		run_clk(ia, icnta, 3'h0, 0, 0, 40, 32'd38, 32'd46);
		run_clk(ia, icnta, 3'h1, 0, 0, 80, 32'd9, 32'd12);
		run_clk(ia, icnta, 3'h2, 0, 0, 300, 32'd1, 32'd3);
		run_clk(ia, icnta, 3'h3, 2, 4, 6, 32'd4, 32'd4);
		run_clk(ia, icnta, 3'h6, 0, 0, 40, 32'd0, 32'd0);
	endtask

	// frozen clock enable drops a write; shaped b phases; a fed by b match and b output
	task automatic t_shaped();
		ce <= 1'b0;
		wr(icmpa, 32'h12);
		ce <= 1'b1;
		rdc(icmpa, 32'hFF);
		wr(icmpl, 32'h03);
		wr(icmph, 32'h01);
		wr(ia, 32'h20);
		wr(ia, 32'hA0);
		wr(ib, 32'h05);
		wr(ib, 32'h85);
		watch(30);
		chk(nb, 32'd10);
		rng(icnta, 32'd9, 32'd11);
		wr(ia, 32'h20);
		wr(ib, 32'h05);
		wr(ia, 32'h28);
		wr(ib, 32'h07);
		wr(ia, 32'hA8);
		wr(ib, 32'h87);
		watch(30);
		chk(nb, 32'd10);
		rng(icnta, 32'd4, 32'd6);
		wr(ia, 32'h0);
		wr(ib, 32'h0);
	endtask

	// main sequence: two cycles of reset, then each scenario in turn
	initial
	begin
		core_clk = 1'b0;
		resetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		ce = 1'b1;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_bits();
		t_solo();
		t_pwm();
		t_cascade();
		t_clocks();
		t_shaped();
		report_and_stop();
	end

	// overall limit in case a scenario stalls outside a bounded wait
	initial
	begin
		#2000000;
		bad_count++;
		report_and_stop();
	end
endmodule
